// ### hw/rip_pkg.sv
// How it works
// - answer only slave address 68h, d0h write form and d1h read form
// - twenty byte locations in ascending order
// - power fail aborts, clears pointer, ignores bus
// - after power returns, stay deaf for recovery
// - start is data falling while clock high
// - stop is data rising while clock high
// - data changes only while clock low
// - msb first bytes, ninth clock acknowledges
// - acknowledge holds data low whole high phase
// - master nack ends read, device releases data
// - pointer write, repeated start, then device transmits
// - pointer advances only on acknowledge clock
// - read keeps sending next byte while master acknowledges
// - freeze clock copies while an addressed transfer points below 08h
// - bare read starts at current pointer
// - first write byte loads pointer, rest stored
// - acknowledge address, word address, every data byte
// - square wave wins the shared output pin
// - clock write completion resets divider chain
// - sub-second location only keeps zero
package rip_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam int unsigned NUM_REGS = 20;
  localparam logic [4:0] LAST_ADDR = 5'h13;
  localparam logic [4:0] CLK_LAST = 5'h07;
  localparam logic [4:0] SUBSEC_ADDR = 5'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned REC_US = 1000;
  localparam int unsigned REC_CYC = REC_US * CLK_MHZ;
  localparam int unsigned REC_W = 20;
  localparam int unsigned FIFO_W = 13;
  localparam int unsigned FIFO_D = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACKA = 3'b010,
    ST_RX = 3'b011,
    ST_ACKR = 3'b100,
    ST_TX = 3'b101,
    ST_ACKT = 3'b110,
    ST_IGN = 3'b111
  } rip_state_t;
endpackage : rip_pkg

// ### hw/rip_fifo.sv
module rip_fifo #(
  parameter int unsigned W = 13,
  parameter int unsigned D = 8
) (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic in_valid, // write request
  output logic in_ready, // room left
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word waiting
  input wire logic out_ready, // drain side accepts
  output logic [W-1:0] out_data // oldest word
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // honest flags straight from the fill count
  assign in_ready = cnt_q != (AW + 1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];

  // storage has no reset, only the pointers and fill count need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  a_fifo_count: assert property (@(posedge clk) disable iff (rst)
    push && !pop |=> cnt_q == $past(cnt_q) + 1'b1) else $error("fifo count lost a push");
endmodule : rip_fifo

// ### hw/rip_mem.sv
module rip_mem (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic we, // write strobe
  input wire logic [4:0] waddr, // write location
  input wire logic [7:0] wdata, // write byte
  input wire logic [4:0] raddr, // read location
  output logic [7:0] rdata // registered read byte
);
  import rip_pkg::*;
  logic [7:0] mem [NUM_REGS];

  // array itself is left unreset, contents belong to the timekeeper
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data registered; out-of-range reads give zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= (raddr <= LAST_ADDR) ? mem[raddr] : 8'h00;
    end
  end
endmodule : rip_mem

// ### hw/rip_port.sv
module rip_port #(
  parameter int unsigned REC_CYCLES = rip_pkg::REC_CYC
) (
  input wire logic clk, // 25 mhz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl_i, // bus clock level
  input wire logic sda_i, // bus data level
  output logic sda_o, // data drive value, always low
  output logic sda_oe_n, // low while pulling data low
  input wire logic pwr_fail, // supply below power_fail_threshold
  input wire logic sqw_en, // square wave enabled
  input wire logic sqw_wave, // square wave level
  input wire logic irq_req, // interrupt asserted
  input wire logic ft_en, // frequency test enabled
  input wire logic ft_wave, // frequency test level
  input wire logic out_level, // static output level
  output logic sdo_o, // shared_open_drain_output drive value
  output logic sdo_oe_n, // low while pulling shared pin low
  output logic freeze_o, // hold time copies
  output logic div_rst_o // one-cycle divider chain reset
);
  import rip_pkg::*;

  rip_state_t state_q, state_d;
  logic scl_q, sda_q, scl_p, sda_p;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] ptr_q, ptr_d;
  logic drv_q, drv_d;
  logic rw_q, rw_d;
  logic first_q, first_d;
  logic push;
  logic active_q, freeze_q, clkwr_q, div_q, sdo_q;
  logic [REC_W-1:0] rec_q;
  logic [7:0] rdata;
  logic f_vld, f_rdy, in_rdy;
  logic [FIFO_W-1:0] f_data;

  // decode of bus events from sampled lines
  wire locked = pwr_fail | (rec_q != '0);
  wire start_w = !locked & scl_q & scl_p & sda_p & !sda_q;
  wire stop_w = !locked & scl_q & scl_p & !sda_p & sda_q;
  wire rise_w = scl_q & !scl_p;
  wire fall_w = !scl_q & scl_p;
  wire match_w = sh_q[7:1] == SLAVE_ADDR;
  wire [4:0] nxt_ptr = (ptr_q >= LAST_ADDR) ? 5'h00 : ptr_q + 5'h01;
  wire sub_bad = (ptr_q == SUBSEC_ADDR) && (sh_q != 8'h00);
  wire act_next = !locked & !stop_w &
                  (active_q | (state_q == ST_ADDR & fall_w & cnt_q == BYTE_BITS & match_w));
  wire [4:0] wa_ptr = (sh_q[4:0] > LAST_ADDR) ? 5'h00 : sh_q[4:0];

  // square wave first, then interrupt, then test, then static level
  wire pin_lvl = sqw_en ? sqw_wave :
                 irq_req ? 1'b0 :
                 ft_en ? ft_wave : out_level;

  assign sda_o = 1'b0;
  assign sda_oe_n = !drv_q;
  assign sdo_o = 1'b0;
  assign sdo_oe_n = sdo_q;
  assign freeze_o = freeze_q;
  assign div_rst_o = div_q;
  // no draining while the next read byte is being fetched
  assign f_rdy = state_q != ST_ACKT;

  // sample the pins and keep the previous level for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  // byte engine; bytes are only acted on at the acknowledge bit
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    drv_d = drv_q;
    rw_d = rw_q;
    first_d = first_q;
    push = 1'b0;
    if (locked) begin
      state_d = ST_IDLE;
      ptr_d = 5'h00;
      drv_d = 1'b0;
    end else if (start_w) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_w) begin
      state_d = ST_IDLE;
      drv_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR: begin
          if (rise_w) begin
            sh_d = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == BYTE_BITS) begin
            if (match_w) begin
              state_d = ST_ACKA;
              drv_d = 1'b1;
              rw_d = sh_q[0];
            end else begin
              state_d = ST_IGN;
            end
          end
        end
        ST_ACKA: begin
          if (fall_w) begin
            cnt_d = 4'h0;
            if (rw_q) begin
              state_d = ST_TX;
              sh_d = rdata;
              drv_d = !rdata[7];
            end else begin
              state_d = ST_RX;
              drv_d = 1'b0;
              first_d = 1'b1;
            end
          end
        end
        ST_RX: begin
          if (rise_w) begin
            sh_d = {sh_q[6:0], sda_q};
            cnt_d = cnt_q + 4'h1;
          end else if (fall_w && cnt_q == BYTE_BITS) begin
            if (first_q || in_rdy) begin
              state_d = ST_ACKR;
              drv_d = 1'b1;
            end else begin
              state_d = ST_IGN; // full buffer: refuse the byte
            end
          end
        end
        ST_ACKR: begin
          if (rise_w) begin
            first_d = 1'b0;
            if (first_q) begin
              ptr_d = wa_ptr;
            end else begin
              push = !sub_bad;
              ptr_d = nxt_ptr;
            end
          end else if (fall_w) begin
            state_d = ST_RX;
            drv_d = 1'b0;
            cnt_d = 4'h0;
          end
        end
        ST_TX: begin
          if (fall_w) begin
            if (cnt_q == LAST_BIT) begin
              state_d = ST_ACKT;
              drv_d = 1'b0;
              cnt_d = 4'h0;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              drv_d = !sh_q[6];
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_ACKT: begin
          if (rise_w) begin
            if (!sda_q) begin
              ptr_d = nxt_ptr;
            end else begin
              state_d = ST_IGN;
            end
          end else if (fall_w) begin
            state_d = ST_TX;
            sh_d = rdata;
            drv_d = !rdata[7];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 5'h00;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      drv_q <= drv_d;
      rw_q <= rw_d;
      first_q <= first_d;
    end
  end

  // recovery lockout reloads for as long as the supply is low
  always_ff @(posedge clk) begin
    if (rst) begin
      rec_q <= '0;
    end else if (pwr_fail) begin
      rec_q <= REC_W'(REC_CYCLES);
    end else if (rec_q != '0) begin
      rec_q <= rec_q - 1'b1;
    end
  end

  // freeze while an addressed transfer points into the clock bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      freeze_q <= 1'b0;
      clkwr_q <= 1'b0;
      div_q <= 1'b0;
      sdo_q <= 1'b1;
    end else begin
      active_q <= act_next;
      freeze_q <= act_next && ptr_d <= CLK_LAST;
      clkwr_q <= (clkwr_q | (push && ptr_q <= CLK_LAST)) & !stop_w & !locked;
      div_q <= stop_w & clkwr_q;
      sdo_q <= pin_lvl;
    end
  end

  // written bytes queue ahead of the register store
  rip_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(in_rdy),
    .in_data({ptr_q, sh_q}),
    .out_valid(f_vld),
    .out_ready(f_rdy),
    .out_data(f_data)
  );

  rip_mem u_mem (
    .clk(clk),
    .rst(rst),
    .we(f_vld & f_rdy),
    .waddr(f_data[12:8]),
    .wdata(f_data[7:0]),
    .raddr(ptr_q),
    .rdata(rdata)
  );

  a_start_addr: assert property (@(posedge clk) disable iff (rst)
    start_w |=> state_q == ST_ADDR && !drv_q) else $error("start not taken");
  a_stop_idle: assert property (@(posedge clk) disable iff (rst)
    stop_w |=> state_q == ST_IDLE ##1 !freeze_o) else $error("stop not taken");
  a_lock_clear: assert property (@(posedge clk) disable iff (rst)
    pwr_fail |=> ptr_q == 5'h00 && state_q == ST_IDLE && sda_oe_n) else $error("no lockout");
  a_rec_deaf: assert property (@(posedge clk) disable iff (rst)
    $fell(pwr_fail) |-> (state_q == ST_IDLE)[*8]) else $error("bus heard during recovery");
  a_addr_ack: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ADDR && fall_w && cnt_q == BYTE_BITS && match_w && !locked && !start_w
    && !stop_w |=> !sda_oe_n && state_q == ST_ACKA) else $error("address not acked");
  a_addr_miss: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ADDR && fall_w && cnt_q == BYTE_BITS && !match_w && !locked && !start_w
    && !stop_w |=> sda_oe_n && state_q == ST_IGN) else $error("foreign address acked");
  a_ptr_step: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ACKR && rise_w && !first_q && !locked
    |=> ptr_q == $past(nxt_ptr)) else $error("pointer did not advance");
  a_nack_free: assert property (@(posedge clk) disable iff (rst)
    state_q == ST_ACKT && rise_w && sda_q && !locked |=> sda_oe_n[*2]) else $error("data held");
  a_sqw_first: assert property (@(posedge clk) disable iff (rst)
    sqw_en |=> sdo_oe_n == $past(sqw_wave)) else $error("square wave lost the pin");
  // watched at the store itself, so a broken push gate cannot hide behind its own term
  a_subsec_zero: assert property (@(posedge clk) disable iff (rst)
    f_vld && f_rdy && f_data[12:8] == SUBSEC_ADDR |-> f_data[7:0] == 8'h00)
    else $error("nonzero sub-second stored");
endmodule : rip_port

// ### verif/rip_bfm.sv
// two-wire bus master model; scl rests high between frames, data rests released
module rip_bfm (
  input wire logic clk, // system clock
  input wire logic sda, // resolved data wire
  output logic scl = 1'b1, // bus clock, high when idle
  output logic sda_low = 1'b0 // high while the master pulls data low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PH = 6; // clock phase in clk cycles, above the four-cycle minimum

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // start from an idle bus; also serves as repeated start with scl low
  task automatic start();
    sda_low <= 1'b0;
    wt(PH);
    scl <= 1'b1;
    wt(PH);
    sda_low <= 1'b1;
    wt(PH);
    scl <= 1'b0;
    wt(PH);
  endtask : start

  task automatic stop();
    sda_low <= 1'b1;
    wt(PH);
    scl <= 1'b1;
    wt(PH);
    sda_low <= 1'b0;
    wt(PH);
  endtask : stop

  // one clock pulse; all_low tells whether data stayed low through the high phase
  task automatic pulse(output logic all_low, output logic mid);
    all_low = 1'b1;
    scl <= 1'b1;
    for (int i = 0; i < PH; i++) begin
      @(posedge clk);
      if (sda !== 1'b0) all_low = 1'b0;
      if (i == PH / 2) mid = sda;
    end
    scl <= 1'b0;
    wt(PH);
  endtask : pulse

  // msb first; a short count leaves the byte unfinished with no ninth clock
  task automatic put(input logic [7:0] b, input int nb, output logic ack);
    logic m;
    ack = 1'b0;
    for (int i = 7; i > 7 - nb; i--) begin
      sda_low <= ~b[i];
      wt(2);
      pulse(m, m);
    end
    if (nb == 8) begin
      sda_low <= 1'b0;
      wt(2);
      pulse(ack, m);
    end
  endtask : put

  task automatic get(input logic ack_me, output logic [7:0] b);
    logic m;
    sda_low <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      wt(2);
      pulse(m, b[i]);
    end
    sda_low <= ack_me;
    wt(2);
    pulse(m, m);
    // release, then let an edge pass so the next call never drives data in this step
    sda_low <= 1'b0;
    wt(1);
  endtask : get
endmodule : rip_bfm

// ### verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rip_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pwr_fail = 1'b0;
  logic [5:0] pin_src = 6'h00; // sqw_en, sqw_wave, irq_req, ft_en, ft_wave, out_level
  wire logic scl, m_low, sda_oe_n, sdo_oe_n, freeze_o, div_rst_o;
  // pull-up wins unless a party pulls low; an unknown enable counts as released
  wire logic sda = !m_low && (sda_oe_n !== 1'b0);
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int div_cnt = 0;

  always #20 clk = ~clk;

  rip_port #(.REC_CYCLES(20)) rip_port_i (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n),
    .pwr_fail(pwr_fail), .sqw_en(pin_src[5]), .sqw_wave(pin_src[4]), .irq_req(pin_src[3]),
    .ft_en(pin_src[2]), .ft_wave(pin_src[1]), .out_level(pin_src[0]), .sdo_o(),
    .sdo_oe_n(sdo_oe_n), .freeze_o(freeze_o), .div_rst_o(div_rst_o)
  );
  rip_bfm rip_bfm_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

  // cycle ceiling well above the roughly 5600 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (div_rst_o === 1'b1) div_cnt <= div_cnt + 1;
    if (cyc == 40000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // write-form address and word address, leaving the pointer at a
  task automatic point(input logic [7:0] a);
    logic ack;
    rip_bfm_i.start();
    rip_bfm_i.put({SLAVE_ADDR, 1'b0}, 8, ack);
    chk("ack slave address", 8'h01, {7'h00, ack});
    rip_bfm_i.put(a, 8, ack);
    chk("ack word address", 8'h01, {7'h00, ack});
  endtask : point

  // single byte at a; freeze follows the pointer, divider reset follows stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dv);
    logic ack;
    int n;
    point(a);
    chk("freeze at start", {7'h00, a <= 8'h07}, {7'h00, freeze_o});
    rip_bfm_i.put(d, 8, ack);
    chk("ack data", 8'h01, {7'h00, ack});
    chk("freeze after advance", {7'h00, a < 8'h07}, {7'h00, freeze_o});
    n = div_cnt;
    rip_bfm_i.stop();
    wt(4);
    chk("divider resets", {7'h00, dv}, 8'(div_cnt - n));
    chk("freeze after stop", 8'h00, {7'h00, freeze_o});
  endtask : wr

  // one byte read, optionally after setting the pointer, ended by nack and stop
  task automatic rd(input logic set, input logic [7:0] a, input logic [7:0] exp);
    logic ack;
    logic [7:0] b;
    if (set) point(a);
    rip_bfm_i.start();
    rip_bfm_i.put({SLAVE_ADDR, 1'b1}, 8, ack);
    chk("ack read address", 8'h01, {7'h00, ack});
    if (set) chk("freeze while reading", {7'h00, a <= 8'h07}, {7'h00, freeze_o});
    rip_bfm_i.get(1'b0, b);
    chk("read byte", exp, b);
    chk("release after nack", 8'h01, {7'h00, sda_oe_n});
    rip_bfm_i.stop();
  endtask : rd

  // back-to-back writes then a burst read across the same two locations
  task automatic t_burst();
    logic ack;
    logic [7:0] b;
    point(8'h02);
    rip_bfm_i.put(8'h5a, 8, ack);
    rip_bfm_i.put(8'ha5, 8, ack);
    chk("ack second byte", 8'h01, {7'h00, ack});
    rip_bfm_i.stop();
    point(8'h02);
    rip_bfm_i.start();
    rip_bfm_i.put({SLAVE_ADDR, 1'b1}, 8, ack);
    rip_bfm_i.get(1'b1, b);
    chk("burst byte 0", 8'h5a, b);
    rip_bfm_i.get(1'b0, b);
    chk("burst byte 1", 8'ha5, b);
    rip_bfm_i.stop();
  endtask : t_burst

  // stop after four bits must drop the byte and keep the pointer
  task automatic t_mid();
    logic ack;
    point(8'h09);
    rip_bfm_i.put(8'h55, 4, ack);
    rip_bfm_i.stop();
    rd(1'b0, 8'h00, 8'h3c);
  endtask : t_mid

  task automatic t_wrong();
    logic ack;
    rip_bfm_i.start();
    rip_bfm_i.put(8'ha0, 8, ack);
    chk("foreign address", 8'h00, {7'h00, ack});
    rip_bfm_i.put({SLAVE_ADDR, 1'b0}, 8, ack);
    chk("traffic after foreign address", 8'h00, {7'h00, ack});
    rip_bfm_i.stop();
  endtask : t_wrong

  // supply loss mid access, then a start inside the recovery interval
  task automatic t_power();
    logic ack;
    point(8'h0c);
    pwr_fail <= 1'b1;
    rip_bfm_i.start();
    rip_bfm_i.put({SLAVE_ADDR, 1'b0}, 8, ack);
    chk("ack during power fail", 8'h00, {7'h00, ack});
    pwr_fail <= 1'b0;
    rip_bfm_i.start();
    rip_bfm_i.put({SLAVE_ADDR, 1'b0}, 8, ack);
    chk("ack during recovery", 8'h00, {7'h00, ack});
    rip_bfm_i.stop();
    rd(1'b0, 8'h00, 8'h00);
  endtask : t_power

  task automatic t_pin();
    logic e;
    for (int i = 0; i < 64; i++) begin
      pin_src <= 6'(i);
      wt(3);
      e = pin_src[5] ? pin_src[4] : pin_src[3] ? 1'b0 : pin_src[2] ? pin_src[1] : pin_src[0];
      chk("shared pin", {7'h00, e}, {7'h00, sdo_oe_n});
    end
  endtask : t_pin

  // main sequence; bytes stored by earlier steps set what later reads expect
  initial begin
    wt(20);
    rst <= 1'b0;
    wt(5);
    t_burst();
    wr(8'h07, 8'h99, 1'b1);
    wr(8'h09, 8'h3c, 1'b0);
    wr(8'h00, 8'h00, 1'b1);
    wr(8'h00, 8'h12, 1'b0);
    rd(1'b1, 8'h00, 8'h00);
    t_mid();
    t_wrong();
    t_power();
    t_pin();
    wrap_up();
  end
endmodule : tb
